/* rtl/sllc_consts.vh */
// Constants of the serial link layer configuration block
// Behaviour
// - Override bit set: LMFC counter loads programmed start value, not default.
// - Five-bit start value is the LMFC reset count, used only with override.
// - Lane alignment start waits 0 to 3 multiframes after code group sync.
// - Scrambler enable bit one scrambles link data, zero sends it plain.
// - Multiframe length K is the five-bit field plus one.
// - Lane ID override zero uses default IDs, one uses programmed IDs.
// - Upper lane ID nibble sets channel A (AB page) or C (CD page).
// - Lower lane ID nibble sets channel B (AB page) or D (CD page).
// - Polynomial select 0..3 picks PRBS7, PRBS15, PRBS23, PRBS31.
// - Reset clears all configuration registers to zero.
// - Polynomial select applies only when test pattern select equals 6.
// - Alignment sequence sent when sync request deasserts, unless disabled.
`ifndef SLLC_CONSTS_VH
`define SLLC_CONSTS_VH

// Register indices; byte address is four times the index
`define SLLC_IDX_TEST_CTL 7'h22
`define SLLC_IDX_LMFC_CTL 7'h23
`define SLLC_IDX_SCR_CTL 7'h25
`define SLLC_IDX_MF_LEN 7'h26
`define SLLC_IDX_LID_CTL 7'h28
`define SLLC_IDX_LID_VAL 7'h2d
`define SLLC_IDX_PRBS_SEL 7'h36
`define SLLC_IDX_BURST_CTL 7'h37
// Address bit that selects the CD page copy
`define SLLC_PAGE_BIT 9

// Storage slots
`define SLLC_SLOT_TEST 3'h0
`define SLLC_SLOT_LMFC 3'h1
`define SLLC_SLOT_SCR 3'h2
`define SLLC_SLOT_MF 3'h3
`define SLLC_SLOT_LIDC 3'h4
`define SLLC_SLOT_LIDV 3'h5
`define SLLC_SLOT_PRBS 3'h6
`define SLLC_SLOT_BURST 3'h7

// Writable bit masks; other bits are reserved
`define SLLC_MASK_TEST 8'he1
`define SLLC_MASK_LMFC 8'hff
`define SLLC_MASK_SCR 8'h80
`define SLLC_MASK_MF 8'h1f
`define SLLC_MASK_LIDC 8'h08
`define SLLC_MASK_LIDV 8'hff
`define SLLC_MASK_PRBS 8'hc0
`define SLLC_MASK_BURST 8'hf8

`define SLLC_RESET_VAL 8'h00

// Field positions
`define SLLC_TEST_SEL_HI 7
`define SLLC_TEST_SEL_LO 5
`define SLLC_ALIGN_DIS_BIT 0
`define SLLC_LMFC_OVR_BIT 7
`define SLLC_LMFC_START_HI 6
`define SLLC_LMFC_START_LO 2
`define SLLC_ALIGN_DLY_HI 1
`define SLLC_ALIGN_DLY_LO 0
`define SLLC_SCR_ON_BIT 7
`define SLLC_MF_HI 4
`define SLLC_MF_LO 0
`define SLLC_LID_OVR_BIT 3
`define SLLC_LID_FIRST_HI 7
`define SLLC_LID_FIRST_LO 4
`define SLLC_LID_SECOND_HI 3
`define SLLC_LID_SECOND_LO 0
`define SLLC_PRBS_HI 7
`define SLLC_PRBS_LO 6

`define SLLC_TEST_SEL_PRBS 3'h6
`define SLLC_LMFC_DEFAULT_START 5'h00
`define SLLC_LID_DEFAULT_A 4'h0
`define SLLC_LID_DEFAULT_B 4'h1
`define SLLC_LID_DEFAULT_C 4'h2
`define SLLC_LID_DEFAULT_D 4'h3
// Alignment sequence countdown load; the sequence ends at the fourth multiframe boundary after it
`define SLLC_ALIGN_SEQ_MF 2'h3

`endif

/* rtl/sllc_lmfc.v */
// LMFC counter for one lane pair
`timescale 1ns/1ps
`include "sllc_consts.vh"
module sllc_lmfc (
    input wire hclk,
    input wire hresetn,
    input wire frame_tick,
    input wire lmfc_reset,
    input wire lmfc_start_override,
    input wire [4:0] lmfc_start_value,
    input wire [4:0] frames_per_multiframe,
    output reg [4:0] lmfc_count_q,
    output reg mf_boundary_q
);
    reg [4:0] lmfc_count_d;
    reg mf_boundary_d;

    always @* begin
        lmfc_count_d = lmfc_count_q;
        mf_boundary_d = 1'b0;
        if (lmfc_reset) begin
            if (lmfc_start_override)
                lmfc_count_d = lmfc_start_value;
            else
                lmfc_count_d = `SLLC_LMFC_DEFAULT_START;
        end else if (frame_tick) begin
            // Start values beyond K-1 wrap at the next frame
            if (lmfc_count_q >= frames_per_multiframe) begin
                lmfc_count_d = 5'h00;
                mf_boundary_d = 1'b1;
            end else begin
                lmfc_count_d = lmfc_count_q + 5'h01;
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lmfc_count_q <= 5'h00;
            mf_boundary_q <= 1'b0;
        end else begin
            lmfc_count_q <= lmfc_count_d;
            mf_boundary_q <= mf_boundary_d;
        end
    end
endmodule // sllc_lmfc

/* rtl/sllc_align.v */
// Lane alignment sequence start control for one lane pair
`timescale 1ns/1ps
`include "sllc_consts.vh"
module sllc_align (
    input wire hclk,
    input wire hresetn,
    input wire sync_req_n,
    input wire cgs_done,
    input wire mf_boundary,
    input wire [1:0] align_seq_delay,
    input wire align_seq_disable,
    output reg ila_active_q,
    output reg link_data_q
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_WAIT = 4'b0010;
    localparam [3:0] ST_ILA = 4'b0100;
    localparam [3:0] ST_DATA = 4'b1000;

    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [1:0] mf_cnt_q;
    reg [1:0] mf_cnt_d;

    always @* begin
        state_d = state_q;
        mf_cnt_d = mf_cnt_q;
        case (state_q)
            ST_IDLE: begin
                if (sync_req_n && cgs_done) begin
                    if (align_seq_disable) begin
                        state_d = ST_DATA;
                    end else if (align_seq_delay == 2'h0) begin
                        state_d = ST_ILA;
                        mf_cnt_d = `SLLC_ALIGN_SEQ_MF;
                    end else begin
                        state_d = ST_WAIT;
                        mf_cnt_d = align_seq_delay;
                    end
                end
            end
            ST_WAIT: begin
                if (mf_boundary) begin
                    if (mf_cnt_q == 2'h1) begin
                        state_d = ST_ILA;
                        mf_cnt_d = `SLLC_ALIGN_SEQ_MF;
                    end else begin
                        mf_cnt_d = mf_cnt_q - 2'h1;
                    end
                end
            end
            ST_ILA: begin
                if (mf_boundary) begin
                    if (mf_cnt_q == 2'h0)
                        state_d = ST_DATA;
                    else
                        mf_cnt_d = mf_cnt_q - 2'h1;
                end
            end
            ST_DATA: begin
                state_d = ST_DATA;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // A fresh sync request restarts the link from any state
        if (!sync_req_n) begin
            state_d = ST_IDLE;
            mf_cnt_d = 2'h0;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
            mf_cnt_q <= 2'h0;
            ila_active_q <= 1'b0;
            link_data_q <= 1'b0;
        end else begin
            state_q <= state_d;
            mf_cnt_q <= mf_cnt_d;
            ila_active_q <= (state_d == ST_ILA);
            link_data_q <= (state_d == ST_DATA);
        end
    end
endmodule // sllc_align

/* rtl/sllc_top.v */
// Link layer configuration registers with AHB-Lite access, AB and CD pages
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "sllc_consts.vh"
module sllc_top (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire frame_tick_ab,
    input wire frame_tick_cd,
    input wire lmfc_reset_ab,
    input wire lmfc_reset_cd,
    input wire cgs_done_ab,
    input wire cgs_done_cd,
    input wire sync_req_n_ab,
    input wire sync_req_n_cd,
    output wire [4:0] lmfc_count_ab,
    output wire [4:0] lmfc_count_cd,
    output wire mf_boundary_ab,
    output wire mf_boundary_cd,
    output wire ila_active_ab,
    output wire ila_active_cd,
    output wire link_data_ab,
    output wire link_data_cd,
    output reg scrambler_on_ab,
    output reg scrambler_on_cd,
    output reg [4:0] mf_length_m1_ab,
    output reg [4:0] mf_length_m1_cd,
    output reg [3:0] lane_id_a,
    output reg [3:0] lane_id_b,
    output reg [3:0] lane_id_c,
    output reg [3:0] lane_id_d,
    output reg prbs_active_ab,
    output reg prbs_active_cd,
    output reg [1:0] prbs_poly_select_ab,
    output reg [1:0] prbs_poly_select_cd
);
    // Storage: index {page, slot}; page 0 is AB, 1 is CD
    reg [7:0] regs_q [0:15];
    reg wr_pend_q;
    reg [3:0] wr_idx_q;
    integer i;

    // Slot of a register index, bit 3 flags a mapped index
    function [3:0] slot_of;
        input [6:0] idx;
        begin
            case (idx)
                `SLLC_IDX_TEST_CTL: slot_of = {1'b1, `SLLC_SLOT_TEST};
                `SLLC_IDX_LMFC_CTL: slot_of = {1'b1, `SLLC_SLOT_LMFC};
                `SLLC_IDX_SCR_CTL: slot_of = {1'b1, `SLLC_SLOT_SCR};
                `SLLC_IDX_MF_LEN: slot_of = {1'b1, `SLLC_SLOT_MF};
                `SLLC_IDX_LID_CTL: slot_of = {1'b1, `SLLC_SLOT_LIDC};
                `SLLC_IDX_LID_VAL: slot_of = {1'b1, `SLLC_SLOT_LIDV};
                `SLLC_IDX_PRBS_SEL: slot_of = {1'b1, `SLLC_SLOT_PRBS};
                `SLLC_IDX_BURST_CTL: slot_of = {1'b1, `SLLC_SLOT_BURST};
                default: slot_of = 4'h0;
            endcase
        end
    endfunction

    // Reserved bits are never stored, so they always read zero
    function [7:0] mask_of;
        input [2:0] slot;
        begin
            case (slot)
                `SLLC_SLOT_TEST: mask_of = `SLLC_MASK_TEST;
                `SLLC_SLOT_LMFC: mask_of = `SLLC_MASK_LMFC;
                `SLLC_SLOT_SCR: mask_of = `SLLC_MASK_SCR;
                `SLLC_SLOT_MF: mask_of = `SLLC_MASK_MF;
                `SLLC_SLOT_LIDC: mask_of = `SLLC_MASK_LIDC;
                `SLLC_SLOT_LIDV: mask_of = `SLLC_MASK_LIDV;
                `SLLC_SLOT_PRBS: mask_of = `SLLC_MASK_PRBS;
                `SLLC_SLOT_BURST: mask_of = `SLLC_MASK_BURST;
                default: mask_of = 8'h00;
            endcase
        end
    endfunction

    // Address phase decode
    wire [3:0] a_slot = slot_of(haddr[8:2]);
    wire a_hit = a_slot[3] && (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
    wire a_take = hsel && htrans[1] && hready;
    wire [3:0] a_idx = {haddr[`SLLC_PAGE_BIT], a_slot[2:0]};
    wire [7:0] wr_data = hwdata[7:0] & mask_of(wr_idx_q[2:0]);
    // Forward a write still in its data phase to a read of the same word
    wire fwd = wr_pend_q && (wr_idx_q == a_idx);
    wire [7:0] rd_byte = fwd ? wr_data : regs_q[a_idx];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_idx_q <= 4'h0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_q <= a_take && hwrite && a_hit;
            if (a_take && hwrite && a_hit)
                wr_idx_q <= a_idx;
            if (a_take && !hwrite)
                hrdata <= a_hit ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (i = 0; i < 16; i = i + 1)
                regs_q[i] <= `SLLC_RESET_VAL;
        end else if (wr_pend_q) begin
            regs_q[wr_idx_q] <= wr_data;
        end
    end

    // Per-page field views
    wire [7:0] test_ab = regs_q[{1'b0, `SLLC_SLOT_TEST}];
    wire [7:0] test_cd = regs_q[{1'b1, `SLLC_SLOT_TEST}];
    wire [7:0] lmfc_ab = regs_q[{1'b0, `SLLC_SLOT_LMFC}];
    wire [7:0] lmfc_cd = regs_q[{1'b1, `SLLC_SLOT_LMFC}];
    wire [7:0] mf_ab = regs_q[{1'b0, `SLLC_SLOT_MF}];
    wire [7:0] mf_cd = regs_q[{1'b1, `SLLC_SLOT_MF}];
    wire [7:0] lidc_ab = regs_q[{1'b0, `SLLC_SLOT_LIDC}];
    wire [7:0] lidc_cd = regs_q[{1'b1, `SLLC_SLOT_LIDC}];
    wire [7:0] lidv_ab = regs_q[{1'b0, `SLLC_SLOT_LIDV}];
    wire [7:0] lidv_cd = regs_q[{1'b1, `SLLC_SLOT_LIDV}];
    wire [7:0] prbs_ab = regs_q[{1'b0, `SLLC_SLOT_PRBS}];
    wire [7:0] prbs_cd = regs_q[{1'b1, `SLLC_SLOT_PRBS}];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scrambler_on_ab <= 1'b0;
            scrambler_on_cd <= 1'b0;
            mf_length_m1_ab <= 5'h00;
            mf_length_m1_cd <= 5'h00;
            lane_id_a <= 4'h0;
            lane_id_b <= 4'h0;
            lane_id_c <= 4'h0;
            lane_id_d <= 4'h0;
            prbs_active_ab <= 1'b0;
            prbs_active_cd <= 1'b0;
            prbs_poly_select_ab <= 2'h0;
            prbs_poly_select_cd <= 2'h0;
        end else begin
            scrambler_on_ab <= regs_q[{1'b0, `SLLC_SLOT_SCR}][`SLLC_SCR_ON_BIT];
            scrambler_on_cd <= regs_q[{1'b1, `SLLC_SLOT_SCR}][`SLLC_SCR_ON_BIT];
            mf_length_m1_ab <= mf_ab[`SLLC_MF_HI:`SLLC_MF_LO];
            mf_length_m1_cd <= mf_cd[`SLLC_MF_HI:`SLLC_MF_LO];
            lane_id_a <= lidc_ab[`SLLC_LID_OVR_BIT] ?
                lidv_ab[`SLLC_LID_FIRST_HI:`SLLC_LID_FIRST_LO] : `SLLC_LID_DEFAULT_A;
            lane_id_b <= lidc_ab[`SLLC_LID_OVR_BIT] ?
                lidv_ab[`SLLC_LID_SECOND_HI:`SLLC_LID_SECOND_LO] : `SLLC_LID_DEFAULT_B;
            lane_id_c <= lidc_cd[`SLLC_LID_OVR_BIT] ?
                lidv_cd[`SLLC_LID_FIRST_HI:`SLLC_LID_FIRST_LO] : `SLLC_LID_DEFAULT_C;
            lane_id_d <= lidc_cd[`SLLC_LID_OVR_BIT] ?
                lidv_cd[`SLLC_LID_SECOND_HI:`SLLC_LID_SECOND_LO] : `SLLC_LID_DEFAULT_D;
            prbs_active_ab <= (test_ab[`SLLC_TEST_SEL_HI:`SLLC_TEST_SEL_LO] == `SLLC_TEST_SEL_PRBS);
            prbs_active_cd <= (test_cd[`SLLC_TEST_SEL_HI:`SLLC_TEST_SEL_LO] == `SLLC_TEST_SEL_PRBS);
            // Held at PRBS7 code outside Prbs_poly_select so the field has no effect
            prbs_poly_select_ab <= (test_ab[`SLLC_TEST_SEL_HI:`SLLC_TEST_SEL_LO] == `SLLC_TEST_SEL_PRBS) ?
                prbs_ab[`SLLC_PRBS_HI:`SLLC_PRBS_LO] : 2'h0;
            prbs_poly_select_cd <= (test_cd[`SLLC_TEST_SEL_HI:`SLLC_TEST_SEL_LO] == `SLLC_TEST_SEL_PRBS) ?
                prbs_cd[`SLLC_PRBS_HI:`SLLC_PRBS_LO] : 2'h0;
        end
    end

    sllc_lmfc u_lmfc_ab (
        .hclk(hclk),
        .hresetn(hresetn),
        .frame_tick(frame_tick_ab),
        .lmfc_reset(lmfc_reset_ab),
        .lmfc_start_override(lmfc_ab[`SLLC_LMFC_OVR_BIT]),
        .lmfc_start_value(lmfc_ab[`SLLC_LMFC_START_HI:`SLLC_LMFC_START_LO]),
        .frames_per_multiframe(mf_ab[`SLLC_MF_HI:`SLLC_MF_LO]),
        .lmfc_count_q(lmfc_count_ab),
        .mf_boundary_q(mf_boundary_ab)
    );

    sllc_lmfc u_lmfc_cd (
        .hclk(hclk),
        .hresetn(hresetn),
        .frame_tick(frame_tick_cd),
        .lmfc_reset(lmfc_reset_cd),
        .lmfc_start_override(lmfc_cd[`SLLC_LMFC_OVR_BIT]),
        .lmfc_start_value(lmfc_cd[`SLLC_LMFC_START_HI:`SLLC_LMFC_START_LO]),
        .frames_per_multiframe(mf_cd[`SLLC_MF_HI:`SLLC_MF_LO]),
        .lmfc_count_q(lmfc_count_cd),
        .mf_boundary_q(mf_boundary_cd)
    );

    sllc_align u_align_ab (
        .hclk(hclk),
        .hresetn(hresetn),
        .sync_req_n(sync_req_n_ab),
        .cgs_done(cgs_done_ab),
        .mf_boundary(mf_boundary_ab),
        .align_seq_delay(lmfc_ab[`SLLC_ALIGN_DLY_HI:`SLLC_ALIGN_DLY_LO]),
        .align_seq_disable(test_ab[`SLLC_ALIGN_DIS_BIT]),
        .ila_active_q(ila_active_ab),
        .link_data_q(link_data_ab)
    );

    sllc_align u_align_cd (
        .hclk(hclk),
        .hresetn(hresetn),
        .sync_req_n(sync_req_n_cd),
        .cgs_done(cgs_done_cd),
        .mf_boundary(mf_boundary_cd),
        .align_seq_delay(lmfc_cd[`SLLC_ALIGN_DLY_HI:`SLLC_ALIGN_DLY_LO]),
        .align_seq_disable(test_cd[`SLLC_ALIGN_DIS_BIT]),
        .ila_active_q(ila_active_cd),
        .link_data_q(link_data_cd)
    );
endmodule // sllc_top

/* bench/sllc_top_assertions.sv */
// Port-level assertions for the link layer configuration block
`timescale 1ns/1ps
module sllc_top_checker (
    input logic hclk,
    input logic hresetn,
    input logic [31:0] hrdata,
    input logic hreadyout,
    input logic hresp,
    input logic frame_tick_ab,
    input logic frame_tick_cd,
    input logic lmfc_reset_ab,
    input logic lmfc_reset_cd,
    input logic [4:0] lmfc_count_ab,
    input logic [4:0] lmfc_count_cd,
    input logic [4:0] mf_length_m1_ab,
    input logic [4:0] mf_length_m1_cd,
    input logic mf_boundary_ab,
    input logic cgs_done_ab,
    input logic sync_req_n_ab,
    input logic ila_active_ab,
    input logic link_data_ab,
    input logic prbs_active_ab,
    input logic prbs_active_cd,
    input logic [1:0] prbs_poly_select_ab,
    input logic [1:0] prbs_poly_select_cd
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_read_upper; hrdata[31:8] == 24'h0; endproperty
    a_read_upper: assert property (p_read_upper) else $error("read data upper bits not zero");
    property p_okay; hreadyout && !hresp; endproperty
    a_okay: assert property (p_okay) else $error("bus response not ready and okay");
    property p_lmfc_step;
        frame_tick_ab && !lmfc_reset_ab && lmfc_count_ab < mf_length_m1_ab |=> lmfc_count_ab == $past(lmfc_count_ab) + 5'h1;
    endproperty
    a_lmfc_step: assert property (p_lmfc_step) else $error("lmfc count did not advance");
    property p_lmfc_wrap;
        frame_tick_cd && !lmfc_reset_cd && lmfc_count_cd >= mf_length_m1_cd |=> lmfc_count_cd == 5'h0;
    endproperty
    a_lmfc_wrap: assert property (p_lmfc_wrap) else $error("lmfc count did not wrap at K");
    property p_lmfc_hold; !frame_tick_ab && !lmfc_reset_ab |=> $stable(lmfc_count_ab); endproperty
    a_lmfc_hold: assert property (p_lmfc_hold) else $error("lmfc count moved without a frame");
    property p_boundary_cause; $rose(mf_boundary_ab) |-> $past(frame_tick_ab) || $past(frame_tick_ab, 2); endproperty
    a_boundary_cause: assert property (p_boundary_cause) else $error("boundary pulse without frame");
    property p_prbs_gate_ab; !prbs_active_ab |-> prbs_poly_select_ab == 2'h0; endproperty
    a_prbs_gate_ab: assert property (p_prbs_gate_ab) else $error("polynomial shown outside prbs_poly_select");
    property p_prbs_gate_cd; !prbs_active_cd |-> prbs_poly_select_cd == 2'h0; endproperty
    a_prbs_gate_cd: assert property (p_prbs_gate_cd) else $error("polynomial shown outside prbs_poly_select");
    property p_ila_excl; !(ila_active_ab && link_data_ab); endproperty
    a_ila_excl: assert property (p_ila_excl) else $error("alignment and data at once");
    property p_sync_drop; !sync_req_n_ab [*2] |=> !ila_active_ab && !link_data_ab; endproperty
    a_sync_drop: assert property (p_sync_drop) else $error("link active during sync request");
    property p_ila_cause; $rose(ila_active_ab) |-> $past(cgs_done_ab) && $past(sync_req_n_ab); endproperty
    a_ila_cause: assert property (p_ila_cause) else $error("alignment started without sync release");
endmodule // sllc_top_checker
bind sllc_top sllc_top_checker u_checker (.hclk(hclk), .hresetn(hresetn), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .frame_tick_ab(frame_tick_ab), .frame_tick_cd(frame_tick_cd), .lmfc_reset_ab(lmfc_reset_ab),
    .lmfc_reset_cd(lmfc_reset_cd), .lmfc_count_ab(lmfc_count_ab), .lmfc_count_cd(lmfc_count_cd),
    .mf_length_m1_ab(mf_length_m1_ab), .mf_length_m1_cd(mf_length_m1_cd), .mf_boundary_ab(mf_boundary_ab),
    .cgs_done_ab(cgs_done_ab), .sync_req_n_ab(sync_req_n_ab), .ila_active_ab(ila_active_ab),
    .link_data_ab(link_data_ab), .prbs_active_ab(prbs_active_ab), .prbs_active_cd(prbs_active_cd),
    .prbs_poly_select_ab(prbs_poly_select_ab), .prbs_poly_select_cd(prbs_poly_select_cd));

/* bench/sllc_top_test.sv */
// Self-checking bench for the link layer configuration block
`timescale 1ns/1ps
`include "sllc_consts.vh"
module sllc_top_test;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    // Index 0 is the AB page, 1 the CD page
    logic [1:0] ft, lr, cg, sn, mfb, ila, lnk, scr, pact;
    logic [4:0] cnt [2];
    logic [4:0] mfl [2];
    logic [1:0] pp [2];
    logic [3:0] lid_a, lid_b, lid_c, lid_d;
    int miscompares = 0;
    int samples_checked = 0;
    logic [6:0] idx_t [8] = '{`SLLC_IDX_TEST_CTL, `SLLC_IDX_LMFC_CTL, `SLLC_IDX_SCR_CTL, `SLLC_IDX_MF_LEN,
        `SLLC_IDX_LID_CTL, `SLLC_IDX_LID_VAL, `SLLC_IDX_PRBS_SEL, `SLLC_IDX_BURST_CTL};
    logic [7:0] msk_t [8] = '{8'he1, 8'hff, 8'h80, 8'h1f, 8'h08, 8'hff, 8'hc0, 8'hf8};
    assign hready = hreadyout;
    sllc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .frame_tick_ab(ft[0]), .frame_tick_cd(ft[1]), .lmfc_reset_ab(lr[0]), .lmfc_reset_cd(lr[1]),
        .cgs_done_ab(cg[0]), .cgs_done_cd(cg[1]), .sync_req_n_ab(sn[0]), .sync_req_n_cd(sn[1]),
        .lmfc_count_ab(cnt[0]), .lmfc_count_cd(cnt[1]), .mf_boundary_ab(mfb[0]), .mf_boundary_cd(mfb[1]),
        .ila_active_ab(ila[0]), .ila_active_cd(ila[1]), .link_data_ab(lnk[0]), .link_data_cd(lnk[1]),
        .scrambler_on_ab(scr[0]), .scrambler_on_cd(scr[1]), .mf_length_m1_ab(mfl[0]), .mf_length_m1_cd(mfl[1]),
        .lane_id_a(lid_a), .lane_id_b(lid_b), .lane_id_c(lid_c), .lane_id_d(lid_d),
        .prbs_active_ab(pact[0]), .prbs_active_cd(pact[1]),
        .prbs_poly_select_ab(pp[0]), .prbs_poly_select_cd(pp[1]));
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            miscompares++;
            end_of_test();
        end
    endtask
    task automatic bus(input logic wr, input logic pg, input logic [6:0] idx, input logic [7:0] wd);
        // Requests start on a clock edge so the address phase is driven there
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, pg, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h0, wd};
        wait_ready();
        rd = hrdata;
    endtask
    task automatic t_regs;
        // Derived outputs load on the first edge after reset release
        cyc(1);
        chk("default lane ids", 32'h0123, {16'h0, lid_a, lid_b, lid_c, lid_d});
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 8; i++) begin
                bus(1'b0, p[0], idx_t[i], 8'h00);
                chk("reset value", 32'h0, rd);
                bus(1'b1, p[0], idx_t[i], 8'hff);
                bus(1'b0, p[0], idx_t[i], 8'h00);
                chk("reserved bits", {24'h0, msk_t[i]}, rd);
            end
            bus(1'b0, p[0], 7'h24, 8'h00);
            chk("unmapped read", 32'h0, rd);
        end
        cyc(2);
        chk("scrambler on", 32'h3, {30'h0, scr});
        chk("multiframe length", 32'h3ff, {22'h0, mfl[1], mfl[0]});
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 8; i++) begin
                bus(1'b1, p[0], idx_t[i], 8'h00);
            end
        end
        cyc(2);
        chk("scrambler off", 32'h0, {30'h0, scr});
    endtask
    task automatic t_lane;
        bus(1'b1, 1'b0, `SLLC_IDX_LID_VAL, 8'h5a);
        bus(1'b1, 1'b1, `SLLC_IDX_LID_VAL, 8'hc3);
        cyc(2);
        chk("lane ids no override", 32'h0123, {16'h0, lid_a, lid_b, lid_c, lid_d});
        bus(1'b1, 1'b0, `SLLC_IDX_LID_CTL, 8'h08);
        bus(1'b1, 1'b1, `SLLC_IDX_LID_CTL, 8'h08);
        cyc(2);
        chk("lane ids programmed", 32'h5ac3, {16'h0, lid_a, lid_b, lid_c, lid_d});
    endtask
    task automatic t_prbs(input int p);
        bus(1'b1, p[0], `SLLC_IDX_PRBS_SEL, 8'hc0);
        bus(1'b1, p[0], `SLLC_IDX_TEST_CTL, 8'he0);
        cyc(2);
        chk("prbs outside mode", 32'h0, {29'h0, pact[p], pp[p]});
        bus(1'b1, p[0], `SLLC_IDX_TEST_CTL, 8'hc0);
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, p[0], `SLLC_IDX_PRBS_SEL, {s[1:0], 6'h0});
            cyc(2);
            chk("prbs polynomial", {30'h1, s[1:0]}, {29'h0, pact[p], pp[p]});
        end
        bus(1'b1, p[0], `SLLC_IDX_TEST_CTL, 8'h00);
    endtask
    task automatic pulse(input int p, input logic tick);
        @(posedge hclk);
        if (tick) ft[p] <= 1'b1;
        else lr[p] <= 1'b1;
        @(posedge hclk);
        ft[p] <= 1'b0;
        lr[p] <= 1'b0;
        #1;
    endtask
    task automatic t_lmfc(input int p);
        logic b;
        bus(1'b1, p[0], `SLLC_IDX_MF_LEN, 8'h04);
        bus(1'b1, p[0], `SLLC_IDX_LMFC_CTL, 8'h8c);
        cyc(2);
        pulse(p, 1'b0);
        chk("lmfc start value", 32'h3, {27'h0, cnt[p]});
        pulse(p, 1'b1);
        chk("lmfc count", 32'h4, {27'h0, cnt[p]});
        pulse(p, 1'b1);
        b = mfb[p];
        chk("lmfc wrap at K", 32'h0, {27'h0, cnt[p]});
        cyc(1);
        chk("boundary pulse", 32'h1, {31'h0, b});
        chk("boundary pulse end", 32'h0, {31'h0, mfb[p]});
        bus(1'b1, p[0], `SLLC_IDX_LMFC_CTL, 8'h0c);
        cyc(2);
        // Step off zero first so the default reload is visible
        pulse(p, 1'b1);
        pulse(p, 1'b0);
        chk("lmfc default start", 32'h0, {27'h0, cnt[p]});
    endtask
    task automatic t_align(input int p);
        int n;
        int b;
        bus(1'b1, p[0], `SLLC_IDX_MF_LEN, 8'h03);
        for (int d = 0; d < 4; d++) begin
            bus(1'b1, p[0], `SLLC_IDX_LMFC_CTL, {6'h0, d[1:0]});
            sn[p] <= 1'b0;
            cg[p] <= 1'b1;
            cyc(3);
            chk("idle on sync request", 32'h0, {30'h0, ila[p], lnk[p]});
            @(posedge hclk);
            sn[p] <= 1'b1;
            cyc(4);
            n = 0;
            b = 0;
            // Ticks start late so a delay of zero shows no boundary at all
            @(posedge hclk);
            while (ila[p] !== 1'b1 && n < 60) begin
                ft[p] <= 1'b1;
                cyc(1);
                n++;
                if (mfb[p] === 1'b1) b++;
            end
            @(posedge hclk);
            ft[p] <= 1'b0;
            if (ila[p] !== 1'b1) begin
                miscompares++;
                end_of_test();
            end
            chk("multiframes before alignment", d, b);
        end
        bus(1'b1, p[0], `SLLC_IDX_TEST_CTL, 8'h01);
        sn[p] <= 1'b0;
        cyc(3);
        @(posedge hclk);
        sn[p] <= 1'b1;
        cyc(4);
        chk("alignment disabled", 32'h1, {30'h0, ila[p], lnk[p]});
    endtask
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        end_of_test();
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        ft = 2'h0;
        lr = 2'h0;
        cg = 2'h0;
        sn = 2'h0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_lane();
        for (int p = 0; p < 2; p++) begin
            t_prbs(p);
            t_lmfc(p);
            t_align(p);
        end
        end_of_test();
    end
endmodule // sllc_top_test
